//--- rtl/ptk_map.vh
`ifndef PTK_MAP_VH
`define PTK_MAP_VH
// Register byte offsets
`define PTK_REG_TIME      12'h000
`define PTK_REG_DATE      12'h004
`define PTK_REG_LEAP_LEN  12'h008
`define PTK_REG_LEAP_DATE 12'h00c
`define PTK_REG_CTRL      12'h010
`define PTK_REG_SLEW      12'h014
`define PTK_REG_SYNC      12'h018
`define PTK_REG_TUNE      12'h01c
`define PTK_REG_TEST      12'h020
`define PTK_REG_STATUS    12'h024
// TIME word fields: hours, minutes, seconds
`define PTK_HR_LSB  16
`define PTK_MIN_LSB 8
`define PTK_SEC_LSB 0
// CTRL bits
`define PTK_CTRL_REMOTE  0
`define PTK_CTRL_STANDBY 1
`define PTK_CTRL_DISPLAY 2
`define PTK_CTRL_LEAP    3
`define PTK_CTRL_FATAL   4
// Limits
`define PTK_MAX_HR   5'd23
`define PTK_MAX_MIN  6'd59
`define PTK_MAX_DATE 17'd99999
`define PTK_LEAP_LEN_RST 7'd60
`define PTK_TEST_ALL  5'h1f
`define PTK_TEST_LAST 5'd17
// Error codes
`define PTK_ERR_NONE   9'd0
`define PTK_ERR_REMOTE 9'd201
`define PTK_ERR_STBY   9'd203
// Sync selection codes
`define PTK_SYNC_OFF   2'd0
`define PTK_SYNC_FRONT 2'd1
`define PTK_SYNC_REAR  2'd2
// Sync timeout
`define PTK_SYNC_TMO_MS 1500
`define PTK_CLK_HZ      20000000
`define PTK_SYNC_TMO_CYC (`PTK_SYNC_TMO_MS * (`PTK_CLK_HZ / 1000))
`endif

//--- rtl/ptk_precision_time.v
// Contract
// - Keep 24-hour time, reject out-of-range values
// - Round supplied time fields to integer
// - Accept day number 0 to 99999 only
// - Day starts at zero, increments at midnight
// - Setting commands need remote mode
// - Refused non-remote setting reports error 201
// - Self-test only in standby or fatal, else 203
// - Selector 0..17 runs one, -1 runs all
// - Test result: 0 pass, 1 fail
// - Display lit when enabled and time set
// - Programmable pre-leap minute length
// - Leap state on schedules with latest values
// - New length while pending reschedules
// - New leap date while pending reschedules
// - Idle leap date reads max of written, current
// - Idle leap length reads last written
// - Leap state reads 1 pending, 0 idle
// - Slew shifts epoch once, 50 ns steps
// - Standby clear resumes; standby reads back
// - Arm front, rear or none; read back
// - Disarm on cancel, pulse or 1.5 s
// - Tuning accepted only in standby
//
// The APB register port and the placing of the registers are this design's own decisions.
`include "ptk_map.vh"
`timescale 1ns/1ps
`default_nettype none
module ptk_precision_time #(
   parameter SYNC_TMO_CYC = `PTK_SYNC_TMO_CYC,
   parameter NTESTS = 18
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire pps_tick,
   input wire sync_front,
   input wire sync_rear,
   input wire [NTESTS-1:0] test_fail,
   output reg display_on,
   output reg [15:0] reference_tuning,
   output reg [22:0] slew_offset,
   output reg slew_pulse,
   output reg [1:0] sync_port_arm,
   output reg [8:0] error_code
);
   reg [4:0] hr_q;
   reg [5:0] min_q;
   reg [5:0] sec_q;
   reg [16:0] day_number_q;
   reg time_set_q;
   reg remote_q;
   reg standby_q;
   reg disp_en_q;
   reg fatal_q;
   reg leap_event_q;
   reg [6:0] leap_len_q;
   reg [16:0] leap_date_q;
   reg leap_done_q;
   reg test_res_q;
   reg [31:0] tmo_q;
   wire wr = psel & penable & pwrite;
   // Read data and error are loaded at setup so they stand with pready
   wire rd = psel & ~penable & ~pwrite;
   // Fields are fixed point with one fraction bit; add half then truncate
   wire [6:0] w_hr = pwdata[`PTK_HR_LSB+7:`PTK_HR_LSB+1] +
                     {6'd0, pwdata[`PTK_HR_LSB]};
   wire [6:0] w_min = pwdata[`PTK_MIN_LSB+7:`PTK_MIN_LSB+1] +
                      {6'd0, pwdata[`PTK_MIN_LSB]};
   wire [6:0] w_sec = pwdata[`PTK_SEC_LSB+7:`PTK_SEC_LSB+1] +
                      {6'd0, pwdata[`PTK_SEC_LSB]};
   wire time_ok = (w_hr <= {2'd0, `PTK_MAX_HR}) &&
                  (w_min <= {1'd0, `PTK_MAX_MIN}) &&
                  (w_sec <= {1'd0, `PTK_MAX_MIN});
   wire date_ok = pwdata[16:0] <= `PTK_MAX_DATE;
   wire setting = (paddr == `PTK_REG_TIME) || (paddr == `PTK_REG_DATE) ||
                  (paddr == `PTK_REG_LEAP_LEN) ||
                  (paddr == `PTK_REG_LEAP_DATE) ||
                  (paddr == `PTK_REG_SLEW) || (paddr == `PTK_REG_SYNC) ||
                  (paddr == `PTK_REG_TUNE);
   wire ctrl_wr = wr && (paddr == `PTK_REG_CTRL);
   // Remote bit itself is always writable so software can enter remote mode
   wire ok_wr = wr && remote_q;
   wire refused = wr && !remote_q &&
                  (setting || (ctrl_wr &&
                   (pwdata[4:1] != {fatal_q, leap_event_q, disp_en_q,
                                    standby_q})));
   wire mapped = setting || ctrl_wr || (paddr == `PTK_REG_CTRL) ||
                 (paddr == `PTK_REG_TEST) || (paddr == `PTK_REG_STATUS);
   // Current minute length is the programmed one only on the leap day's last
   wire leap_min = leap_event_q && (day_number_q == leap_date_q) &&
                   (hr_q == `PTK_MAX_HR) && (min_q == `PTK_MAX_MIN);
   wire [6:0] min_end = leap_min ? leap_len_q - 7'd1 : 7'd59;
   wire sec_wrap = ({1'b0, sec_q} >= min_end);
   wire midnight = sec_wrap && (min_q == `PTK_MAX_MIN) &&
                   (hr_q == `PTK_MAX_HR);
   // Test selector -1 in low 5 bits selects the full set
   wire [4:0] tsel = pwdata[4:0];
   wire test_all = (tsel == `PTK_TEST_ALL);
   wire test_sel_ok = test_all || (tsel <= `PTK_TEST_LAST);
   wire test_allowed = standby_q || fatal_q;
   // Leap date read: the larger of stored and today when idle
   wire [16:0] leap_date_rd = (!leap_event_q && day_number_q > leap_date_q) ?
                              day_number_q : leap_date_q;
   wire [NTESTS-1:0] sel_mask;
   genvar gi;
   generate
      for (gi = 0; gi < NTESTS; gi = gi + 1) begin : g_sel
         assign sel_mask[gi] = test_all || (tsel == gi);
      end
   endgenerate
   wire [31:0] tmo_last = SYNC_TMO_CYC - 1;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hr_q <= 5'd0;
         min_q <= 6'd0;
         sec_q <= 6'd0;
         day_number_q <= 17'd0;
         time_set_q <= 1'b0;
         remote_q <= 1'b0;
         standby_q <= 1'b0;
         disp_en_q <= 1'b0;
         fatal_q <= 1'b0;
         leap_event_q <= 1'b0;
         leap_len_q <= `PTK_LEAP_LEN_RST;
         leap_date_q <= 17'd0;
         leap_done_q <= 1'b0;
         test_res_q <= 1'b0;
         tmo_q <= 32'd0;
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         display_on <= 1'b0;
         reference_tuning <= 16'h0000;
         slew_offset <= 23'h000000;
         slew_pulse <= 1'b0;
         sync_port_arm <= `PTK_SYNC_OFF;
         error_code <= `PTK_ERR_NONE;
      end else begin
         pready <= psel & ~penable;
         pslverr <= 1'b0;
         slew_pulse <= 1'b0;
         leap_done_q <= 1'b0;
         // Timekeeping
         if (pps_tick) begin
            if (sec_wrap) begin
               sec_q <= 6'd0;
               if (min_q == `PTK_MAX_MIN) begin
                  min_q <= 6'd0;
                  if (hr_q == `PTK_MAX_HR)
                     hr_q <= 5'd0;
                  else
                     hr_q <= hr_q + 5'd1;
               end else begin
                  min_q <= min_q + 6'd1;
               end
            end else begin
               sec_q <= sec_q + 6'd1;
            end
            if (midnight) begin
               day_number_q <= (day_number_q == `PTK_MAX_DATE) ?
                               17'd0 : day_number_q + 17'd1;
               if (leap_min)
                  leap_event_q <= 1'b0;
            end
         end
         // Sync arming; a tick alone never disarms
         if (sync_port_arm != `PTK_SYNC_OFF) begin
            tmo_q <= tmo_q + 32'd1;
            if ((sync_port_arm == `PTK_SYNC_FRONT && sync_front) ||
                (sync_port_arm == `PTK_SYNC_REAR && sync_rear) ||
                tmo_q >= tmo_last)
               sync_port_arm <= `PTK_SYNC_OFF;
         end
         display_on <= disp_en_q && time_set_q;
         if (psel && !penable)
            pslverr <= !mapped;
         if (rd) begin
               case (paddr)
                  `PTK_REG_TIME: prdata <= {11'd0, hr_q, 2'd0, min_q,
                                            2'd0, sec_q};
                  `PTK_REG_DATE: prdata <= {15'd0, day_number_q};
                  `PTK_REG_LEAP_LEN: prdata <= {25'd0, leap_len_q};
                  `PTK_REG_LEAP_DATE: prdata <= {15'd0, leap_date_rd};
                  `PTK_REG_CTRL: prdata <= {27'd0, fatal_q, leap_event_q,
                                            disp_en_q, standby_q,
                                            remote_q};
                  `PTK_REG_SLEW: prdata <= {9'd0, slew_offset};
                  `PTK_REG_SYNC: prdata <= {30'd0, sync_port_arm};
                  `PTK_REG_TUNE: prdata <= {16'd0, reference_tuning};
                  `PTK_REG_TEST: prdata <= {31'd0, test_res_q};
                  `PTK_REG_STATUS: prdata <= {22'd0, display_on, error_code};
                  default: prdata <= 32'h0000_0000;
               endcase
         end
         // Bus access phase; pready high at this edge completes it
         if (psel && penable && pready) begin
            pready <= 1'b0;
            if (refused)
               error_code <= `PTK_ERR_REMOTE;
            if (wr && paddr == `PTK_REG_STATUS)
               error_code <= `PTK_ERR_NONE;
            if (ctrl_wr) begin
               remote_q <= pwdata[`PTK_CTRL_REMOTE];
               if (remote_q) begin
                  standby_q <= pwdata[`PTK_CTRL_STANDBY];
                  disp_en_q <= pwdata[`PTK_CTRL_DISPLAY];
                  fatal_q <= pwdata[`PTK_CTRL_FATAL];
                  // Turning on uses the latest length and date
                  leap_event_q <= pwdata[`PTK_CTRL_LEAP];
               end
            end
            if (ok_wr) begin
               case (paddr)
                  `PTK_REG_TIME: if (time_ok) begin
                     hr_q <= w_hr[4:0];
                     min_q <= w_min[5:0];
                     sec_q <= w_sec[5:0];
                     time_set_q <= 1'b1;
                  end
                  `PTK_REG_DATE: if (date_ok)
                     day_number_q <= pwdata[16:0];
                  // Pending event picks up the new length in place
                  `PTK_REG_LEAP_LEN: if (pwdata[6:0] != 7'd0)
                     leap_len_q <= pwdata[6:0];
                  `PTK_REG_LEAP_DATE: if (date_ok)
                     leap_date_q <= pwdata[16:0];
                  `PTK_REG_SLEW: begin
                     slew_offset <= pwdata[22:0];
                     slew_pulse <= 1'b1;
                  end
                  `PTK_REG_SYNC: begin
                     sync_port_arm <= (pwdata[1:0] == 2'd3) ?
                                      `PTK_SYNC_OFF : pwdata[1:0];
                     tmo_q <= 32'd0;
                  end
                  `PTK_REG_TUNE: if (standby_q)
                     reference_tuning <= pwdata[15:0];
                  default: ;
               endcase
            end
            if (wr && paddr == `PTK_REG_TEST) begin
               if (!test_allowed)
                  error_code <= `PTK_ERR_STBY;
               else if (test_sel_ok)
                  test_res_q <= |(test_fail & sel_mask);
            end
         end
      end
   end
endmodule
`default_nettype wire

//--- sim/ptk_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module ptk_host_model (
   input wire logic pclk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   initial {psel, penable, pwrite, paddr, pwdata} = '0;
   // Request held until ready is sampled high, then released
   task automatic acc(input logic w, input logic [11:0] a,
         input logic [31:0] d, output logic [31:0] q, output logic e);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 64);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule
`default_nettype wire

//--- sim/ptk_precision_time_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "ptk_map.vh"
module ptk_checker #(
   parameter int SYNC_TMO_CYC = 100
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic pready,
   input wire logic sync_front,
   input wire logic slew_pulse,
   input wire logic [15:0] reference_tuning,
   input wire logic [1:0] sync_port_arm,
   input wire logic [8:0] error_code
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   localparam int TMO_MAX = SYNC_TMO_CYC + 3;
   logic [31:0] arm_cnt_q;
   wire wr_any = psel && pwrite;
   wire wr_sync = wr_any && paddr == `PTK_REG_SYNC;
   wire wr_tune = wr_any && paddr == `PTK_REG_TUNE;
   wire wr_slew = wr_any && paddr == `PTK_REG_SLEW;
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_front_hit;
      sync_port_arm == `PTK_SYNC_FRONT && sync_front && !wr_sync;
   endsequence
   // Counts how long a port stays armed without a fresh arming write
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         arm_cnt_q <= '0;
      else if (sync_port_arm == `PTK_SYNC_OFF || wr_sync)
         arm_cnt_q <= '0;
      else
         arm_cnt_q <= arm_cnt_q + 32'h1;
   end
   a_ready_setup: assert property (s_setup |=> pready)
      else $error("ready missing after setup");
   a_ready_access: assert property (pready |-> psel && penable
      && !$past(pready))
      else $error("ready outside a single access cycle");
   a_refuse_code: assert property ($changed(error_code) && error_code
      == `PTK_ERR_REMOTE |-> $past(wr_any) || $past(wr_any, 2))
      else $error("remote error without a write");
   a_stby_code: assert property ($changed(error_code) && error_code
      == `PTK_ERR_STBY |-> $past(wr_any) || $past(wr_any, 2))
      else $error("standby error without a write");
   a_slew_once: assert property (slew_pulse |-> ($past(wr_slew)
      || $past(wr_slew, 2)) ##1 !slew_pulse)
      else $error("slew event not single or uncaused");
   a_tune_cause: assert property ($changed(reference_tuning)
      |-> $past(wr_tune) || $past(wr_tune, 2))
      else $error("tuning changed without a write");
   a_arm_cause: assert property ($changed(sync_port_arm) && sync_port_arm
      != `PTK_SYNC_OFF |-> sync_port_arm != 2'd3
      && ($past(wr_sync) || $past(wr_sync, 2)))
      else $error("bad or uncaused sync arming");
   a_sync_pulse: assert property (s_front_hit |-> ##[1:3]
      sync_port_arm == `PTK_SYNC_OFF)
      else $error("sync pulse did not disarm");
   a_sync_tmo: assert property (arm_cnt_q <= TMO_MAX)
      else $error("sync arming outlived its timeout");
endmodule
bind ptk_precision_time ptk_checker #(.SYNC_TMO_CYC(SYNC_TMO_CYC))
   i_ptk_checker (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .pready, .sync_front, .slew_pulse, .reference_tuning, .sync_port_arm,
   .error_code);
`default_nettype wire

//--- sim/ptk_precision_time_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "ptk_map.vh"
module ptk_precision_time_tb;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic pps_tick = 1'b0;
   logic sync_front = 1'b0;
   logic sync_rear = 1'b0;
   logic [17:0] test_fail = '0;
   logic psel, penable, pwrite, pready, pslverr, display_on, slew_pulse, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] reference_tuning;
   logic [22:0] slew_offset;
   logic [1:0] sync_port_arm;
   logic [8:0] error_code;
   int errors = 0;
   int n_compared = 0;
   ptk_precision_time #(.SYNC_TMO_CYC(100)) i_ptk_precision_time (.pclk,
      .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .pps_tick, .sync_front, .sync_rear, .test_fail, .display_on,
      .reference_tuning, .slew_offset, .slew_pulse, .sync_port_arm,
      .error_code);
   ptk_host_model i_ptk_host_model (.pclk, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr);
   task automatic cmp(input logic [31:0] s, input logic [31:0] e);
      n_compared++;
      if (s !== e) begin
         errors++;
         $display("wrong value at %0t: saw %h, expected %h", $time, s, e);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      i_ptk_host_model.acc(1'b1, a, d, rd, err);
      // Let the write settle before outputs are looked at
      @(negedge pclk);
   endtask
   task automatic ck(input logic [11:0] a, input logic [31:0] e);
      i_ptk_host_model.acc(1'b0, a, 32'h0, rd, err);
      cmp(rd, e);
   endtask
   task automatic pulse(input logic [1:0] k);
      @(posedge pclk);
      {sync_rear, sync_front, pps_tick} <= 3'b001 << k;
      @(posedge pclk);
      {sync_rear, sync_front, pps_tick} <= 3'b000;
   endtask
   task automatic done(input string s);
      $display("test %s over", s);
   endtask
   function automatic logic [31:0] tw(logic [7:0] h, m, s);
      tw = {8'h0, h, m, s};
   endfunction
   task automatic complete_run;
      $display("compared %0d, wrong %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial forever #25 pclk = ~pclk;
   initial begin
      #200us;
      errors++;
      complete_run;
   end
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      ck(`PTK_REG_CTRL, 32'h0);
      ck(`PTK_REG_LEAP_LEN, 32'h3c);
      ck(12'h040, 32'h0);
      cmp(err, 32'h1);
      wr(`PTK_REG_TIME, tw(8'h1, 8'h2, 8'h3) << 1);
      ck(`PTK_REG_STATUS, 32'h0c9);
      ck(`PTK_REG_TIME, 32'h0);
      wr(`PTK_REG_STATUS, 32'h0);
      wr(`PTK_REG_CTRL, 32'h1);
      wr(`PTK_REG_CTRL, 32'h5);
      cmp(display_on, 32'h0);
      wr(`PTK_REG_TIME, (tw(8'h17, 8'h3b, 8'h3a) << 1) | 32'h1);
      ck(`PTK_REG_TIME, tw(8'h17, 8'h3b, 8'h3b));
      wr(`PTK_REG_TIME, tw(8'h18, 8'h0, 8'h0) << 1);
      ck(`PTK_REG_TIME, tw(8'h17, 8'h3b, 8'h3b));
      ck(`PTK_REG_STATUS, 32'h200);
      wr(`PTK_REG_DATE, 32'h186a0);
      ck(`PTK_REG_DATE, 32'h0);
      wr(`PTK_REG_DATE, 32'h1869e);
      pulse(2'd0);
      ck(`PTK_REG_TIME, 32'h0);
      ck(`PTK_REG_DATE, 32'h1869f);
      done("time");
      wr(`PTK_REG_LEAP_DATE, 32'h5);
      ck(`PTK_REG_LEAP_DATE, 32'h1869f);
      wr(`PTK_REG_LEAP_LEN, 32'h3d);
      ck(`PTK_REG_LEAP_LEN, 32'h3d);
      wr(`PTK_REG_CTRL, 32'hd);
      ck(`PTK_REG_CTRL, 32'hd);
      wr(`PTK_REG_LEAP_LEN, 32'h3e);
      ck(`PTK_REG_LEAP_LEN, 32'h3e);
      wr(`PTK_REG_LEAP_DATE, 32'h7);
      ck(`PTK_REG_LEAP_DATE, 32'h7);
      wr(`PTK_REG_CTRL, 32'h5);
      ck(`PTK_REG_CTRL, 32'h5);
      done("leap");
      wr(`PTK_REG_TEST, 32'h0);
      ck(`PTK_REG_STATUS, 32'h2cb);
      wr(`PTK_REG_STATUS, 32'h0);
      wr(`PTK_REG_CTRL, 32'h7);
      ck(`PTK_REG_CTRL, 32'h7);
      for (int i = 0; i < 18; i++) begin
         test_fail <= 18'h1 << i;
         wr(`PTK_REG_TEST, i);
         ck(`PTK_REG_TEST, 32'h1);
         wr(`PTK_REG_TEST, (i + 1) % 18);
         ck(`PTK_REG_TEST, 32'h0);
      end
      wr(`PTK_REG_TEST, `PTK_TEST_ALL);
      ck(`PTK_REG_TEST, 32'h1);
      test_fail <= '0;
      wr(`PTK_REG_TEST, `PTK_TEST_ALL);
      ck(`PTK_REG_TEST, 32'h0);
      wr(`PTK_REG_TUNE, 32'h8001);
      cmp(reference_tuning, 32'h8001);
      wr(`PTK_REG_CTRL, 32'h5);
      wr(`PTK_REG_TUNE, 32'h42);
      cmp(reference_tuning, 32'h8001);
      wr(`PTK_REG_SLEW, 32'hffffffff);
      cmp(slew_offset, 32'h7fffff);
      done("standby");
      wr(`PTK_REG_SYNC, `PTK_SYNC_FRONT);
      cmp(sync_port_arm, 32'h1);
      pulse(2'd1);
      ck(`PTK_REG_SYNC, `PTK_SYNC_OFF);
      wr(`PTK_REG_SYNC, `PTK_SYNC_REAR);
      pulse(2'd1);
      ck(`PTK_REG_SYNC, `PTK_SYNC_REAR);
      wr(`PTK_REG_SYNC, `PTK_SYNC_OFF);
      ck(`PTK_REG_SYNC, `PTK_SYNC_OFF);
      wr(`PTK_REG_SYNC, `PTK_SYNC_REAR);
      repeat (85) @(posedge pclk);
      ck(`PTK_REG_SYNC, `PTK_SYNC_REAR);
      repeat (20) @(posedge pclk);
      ck(`PTK_REG_SYNC, `PTK_SYNC_OFF);
      done("sync");
      complete_run;
   end
endmodule
`default_nettype wire
